// [core/caf_acceptance_filter.sv]
// Acceptance filter top: register file on AXI4-Lite, mailbox and FIFO filters, mode and sleep control
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
module caf_acceptance_filter
	import caf_pkg::*;
#(
	parameter int NUM_MB = CAF_NUM_MB,
	localparam int MB_W = $clog2(NUM_MB)
)(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [CAF_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [CAF_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rxValid,
	input wire logic [CAF_EID_W-1:0] rxId,
	input wire logic rxIde,
	input wire logic rxRtr,
	input wire logic frameTxBusy,
	input wire logic frameRxBusy,
	output logic rxAccept,
	output logic [MB_W-1:0] rxMailbox,
	output logic rxFifoStore,
	output logic moduleClkEn
);
	localparam int NUM_MASK = NUM_MB / CAF_MB_PER_MASK;
	localparam int MK_W = $clog2(NUM_MASK);
	localparam int FIFO_FIRST = NUM_MB - CAF_FIFO_BOXES;

	typedef struct packed {
		logic [1:0] idFormat;
		logic fifoMode;
		logic [1:0] opReq;
		logic sleepReq;
		caf_mode_e mode;
		logic [31:0] fifoCmpA;
		logic [31:0] fifoCmpB;
		logic [NUM_MASK-1:0][31:0] mask;
		logic [NUM_MB-1:0] rxEn;
		logic [NUM_MB-1:0][31:0] mbId;
		logic awHeld;
		logic [CAF_ADDR_W-1:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic accept;
		logic [MB_W-1:0] mbIdx;
		logic fifoStore;
	} caf_state_s;
	caf_state_s st;
	caf_state_s next_st;

	logic [NUM_MB-1:0] mbHit;
	logic [NUM_MB-1:0] mbEligible;
	logic fifoHitA;
	logic fifoHitB;
	logic rxTaken;
	logic supLoad;
	logic [CAF_SUP_W-1:0] supportWord;
	logic [31:0] ctlWord;
	logic [31:0] statWord;
	logic [31:0] rdWord;
	logic rdHit;
	logic [31:0] wMerged;
	logic anyMb;
	logic [MB_W-1:0] hitIdx;
	logic [CAF_ADDR_W-1:0] rdMkOfs;
	logic [CAF_ADDR_W-1:0] rdMbOfs;
	logic [CAF_ADDR_W-1:0] wrMkOfs;
	logic [CAF_ADDR_W-1:0] wrMbOfs;

	// Byte-lane merge of a write into the current register value
	function automatic logic [31:0] caf_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction

	// One comparator per mailbox; mask k serves four neighbouring mailboxes
	for (genvar j = 0; j < NUM_MB; j++) begin : g_mb
		caf_id_match u_match (
			.rxId(rxId),
			.rxIde(rxIde),
			.rxRtr(rxRtr),
			.progWord(st.mbId[j]),
			.maskWord(st.mask[j / CAF_MB_PER_MASK]),
			.idFormat(st.idFormat),
			.hit(mbHit[j])
		);
		// FIFO mailboxes leave the mailbox comparison in FIFO mode
		assign mbEligible[j] = mbHit[j] && st.rxEn[j] && !(st.fifoMode && (j >= FIFO_FIRST));
	end

	// Two independent FIFO filters on the two highest mask registers
	caf_id_match u_fifo_a (
		.rxId(rxId),
		.rxIde(rxIde),
		.rxRtr(rxRtr),
		.progWord(st.fifoCmpA),
		.maskWord(st.mask[NUM_MASK-2]),
		.idFormat(st.idFormat),
		.hit(fifoHitA)
	);
	caf_id_match u_fifo_b (
		.rxId(rxId),
		.rxIde(rxIde),
		.rxRtr(rxRtr),
		.progWord(st.fifoCmpB),
		.maskWord(st.mask[NUM_MASK-1]),
		.idFormat(st.idFormat),
		.hit(fifoHitB)
	);

	caf_filter_support u_support (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.load(supLoad),
		.sid(rxId[CAF_EID_W-1:CAF_POS_SID_LO]),
		.supportWord(supportWord)
	);

	// Nothing is received unless the module runs; sleep gates the whole receive path
	assign rxTaken = rxValid && (st.mode == CAF_MODE_OPERATE);
	assign supLoad = rxTaken && !rxIde;

	// Readable words and read decode
	always_comb begin
		ctlWord = '0;
		ctlWord[CAF_POS_IDFM +: 2] = st.idFormat;
		ctlWord[CAF_POS_FIFO] = st.fifoMode;
		ctlWord[CAF_POS_OPM +: 2] = st.opReq;
		ctlWord[CAF_POS_SLEEP] = st.sleepReq;
		statWord = '0;
		statWord[CAF_POS_RST_ST] = (st.mode == CAF_MODE_RESET) || (st.mode == CAF_MODE_SLEEP_RST);
		statWord[CAF_POS_HALT_ST] = (st.mode == CAF_MODE_HALT) || (st.mode == CAF_MODE_SLEEP_HALT);
		statWord[CAF_POS_SLEEP_ST] = (st.mode == CAF_MODE_SLEEP_RST) || (st.mode == CAF_MODE_SLEEP_HALT);
		rdMkOfs = (s_axi_araddr - CAF_OFS_MASK_BASE) >> 2;
		rdMbOfs = (s_axi_araddr - CAF_OFS_MB_BASE) >> 2;
		rdHit = 1'b1;
		rdWord = '0;
		if (s_axi_araddr[CAF_ADDR_W-1:2] == CAF_OFS_CONTROL[CAF_ADDR_W-1:2]) begin
			rdWord = ctlWord;
		end else if (s_axi_araddr[CAF_ADDR_W-1:2] == CAF_OFS_STATUS[CAF_ADDR_W-1:2]) begin
			rdWord = statWord;
		end else if (s_axi_araddr[CAF_ADDR_W-1:2] == CAF_OFS_SUPPORT[CAF_ADDR_W-1:2]) begin
			rdWord[CAF_SUP_W-1:0] = supportWord;
		end else if (s_axi_araddr[CAF_ADDR_W-1:2] == CAF_OFS_FIFO_CMP_A[CAF_ADDR_W-1:2]) begin
			rdWord = st.fifoCmpA;
		end else if (s_axi_araddr[CAF_ADDR_W-1:2] == CAF_OFS_FIFO_CMP_B[CAF_ADDR_W-1:2]) begin
			rdWord = st.fifoCmpB;
		end else if (s_axi_araddr[CAF_ADDR_W-1:2] == CAF_OFS_RX_ENABLE[CAF_ADDR_W-1:2]) begin
			rdWord[NUM_MB-1:0] = st.rxEn;
		end else if ((s_axi_araddr >= CAF_OFS_MASK_BASE) && (rdMkOfs < NUM_MASK)) begin
			rdWord = st.mask[rdMkOfs[MK_W-1:0]];
		end else if ((s_axi_araddr >= CAF_OFS_MB_BASE) && (rdMbOfs < NUM_MB)) begin
			rdWord = st.mbId[rdMbOfs[MB_W-1:0]];
		end else begin
			rdHit = 1'b0;
		end
	end

	// Lowest-numbered eligible mailbox wins
	always_comb begin
		anyMb = 1'b0;
		hitIdx = '0;
		for (int j = NUM_MB - 1; j >= 0; j--) begin
			if (mbEligible[j]) begin
				anyMb = 1'b1;
				hitIdx = MB_W'(j);
			end
		end
	end

	// Bus slave, register writes, mode control and acceptance decision
	always_comb begin
		next_st = st;
		next_st.accept = 1'b0;
		next_st.fifoStore = 1'b0;
		wrMkOfs = (st.awAddr - CAF_OFS_MASK_BASE) >> 2;
		wrMbOfs = (st.awAddr - CAF_OFS_MB_BASE) >> 2;
		wMerged = '0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end
		// Commit once address and data are both held; the response follows in the next cycle
		if (st.awHeld && st.wHeld && !st.bValid) begin
			next_st.awHeld = 1'b0;
			next_st.wHeld = 1'b0;
			next_st.bValid = 1'b1;
			next_st.bResp = CAF_RESP_OKAY;
			if (st.awAddr[CAF_ADDR_W-1:2] == CAF_OFS_CONTROL[CAF_ADDR_W-1:2]) begin
				wMerged = caf_merge(ctlWord, st.wData, st.wStrb);
				next_st.idFormat = wMerged[CAF_POS_IDFM +: 2];
				next_st.fifoMode = wMerged[CAF_POS_FIFO];
				next_st.opReq = wMerged[CAF_POS_OPM +: 2];
				next_st.sleepReq = wMerged[CAF_POS_SLEEP];
			end else if (st.awAddr[CAF_ADDR_W-1:2] == CAF_OFS_FIFO_CMP_A[CAF_ADDR_W-1:2]) begin
				next_st.fifoCmpA = caf_merge(st.fifoCmpA, st.wData, st.wStrb);
			end else if (st.awAddr[CAF_ADDR_W-1:2] == CAF_OFS_FIFO_CMP_B[CAF_ADDR_W-1:2]) begin
				next_st.fifoCmpB = caf_merge(st.fifoCmpB, st.wData, st.wStrb);
			end else if (st.awAddr[CAF_ADDR_W-1:2] == CAF_OFS_RX_ENABLE[CAF_ADDR_W-1:2]) begin
				wMerged = caf_merge(32'(st.rxEn), st.wData, st.wStrb);
				next_st.rxEn = wMerged[NUM_MB-1:0];
			end else if ((st.awAddr >= CAF_OFS_MASK_BASE) && (wrMkOfs < NUM_MASK)) begin
				next_st.mask[wrMkOfs[MK_W-1:0]] = caf_merge(st.mask[wrMkOfs[MK_W-1:0]], st.wData, st.wStrb);
			end else if ((st.awAddr >= CAF_OFS_MB_BASE) && (wrMbOfs < NUM_MB)) begin
				next_st.mbId[wrMbOfs[MB_W-1:0]] = caf_merge(st.mbId[wrMbOfs[MB_W-1:0]], st.wData, st.wStrb);
			end else if ((st.awAddr[CAF_ADDR_W-1:2] != CAF_OFS_STATUS[CAF_ADDR_W-1:2])
				&& (st.awAddr[CAF_ADDR_W-1:2] != CAF_OFS_SUPPORT[CAF_ADDR_W-1:2])) begin
				next_st.bResp = CAF_RESP_SLVERR;
			end
		end
		if (st.bValid && s_axi_bready) begin
			next_st.bValid = 1'b0;
		end
		// Read data are captured at the address handshake and held until taken
		if (s_axi_arvalid && s_axi_arready) begin
			next_st.rValid = 1'b1;
			next_st.rData = rdWord;
			next_st.rResp = rdHit ? CAF_RESP_OKAY : CAF_RESP_SLVERR;
		end else if (st.rValid && s_axi_rready) begin
			next_st.rValid = 1'b0;
		end
		// Leaving operation waits for the transmit frame, halt also for the receive frame; sleep is reachable only from reset or halt
		unique case (st.mode)
			CAF_MODE_OPERATE: begin
				if (st.opReq[0] && !frameTxBusy) begin
					next_st.mode = CAF_MODE_RESET;
				end else if ((st.opReq == CAF_OPM_HALT) && !frameTxBusy && !frameRxBusy) begin
					next_st.mode = CAF_MODE_HALT;
				end
			end
			CAF_MODE_RESET: begin
				if (st.sleepReq) begin
					next_st.mode = CAF_MODE_SLEEP_RST;
				end else if (st.opReq == CAF_OPM_HALT) begin
					next_st.mode = CAF_MODE_HALT;
				end else if (st.opReq == CAF_OPM_OPERATE) begin
					next_st.mode = CAF_MODE_OPERATE;
				end
			end
			CAF_MODE_HALT: begin
				if (st.sleepReq) begin
					next_st.mode = CAF_MODE_SLEEP_HALT;
				end else if (st.opReq[0]) begin
					next_st.mode = CAF_MODE_RESET;
				end else if (st.opReq == CAF_OPM_OPERATE) begin
					next_st.mode = CAF_MODE_OPERATE;
				end
			end
			CAF_MODE_SLEEP_RST: begin
				if (!st.sleepReq) begin
					next_st.mode = CAF_MODE_RESET;
				end
			end
			CAF_MODE_SLEEP_HALT: begin
				if (!st.sleepReq) begin
					next_st.mode = CAF_MODE_HALT;
				end
			end
			default: begin
				next_st.mode = CAF_MODE_RESET;
			end
		endcase
		// Mailboxes take priority; the FIFO catches what passes either of its filters
		if (rxTaken) begin
			if (anyMb) begin
				next_st.accept = 1'b1;
				next_st.mbIdx = hitIdx;
			end else if (st.fifoMode && (fifoHitA || fifoHitB)) begin
				next_st.fifoStore = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.opReq <= CAF_OPM_RST;
			st.idFormat <= CAF_IDFM_RST;
			st.mode <= CAF_MODE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Handshakes are combinational; one write and one read in flight
	assign s_axi_awready = !st.awHeld && !st.bValid;
	assign s_axi_wready = !st.wHeld && !st.bValid;
	assign s_axi_bvalid = st.bValid;
	assign s_axi_bresp = st.bResp;
	assign s_axi_arready = !st.rValid;
	assign s_axi_rvalid = st.rValid;
	assign s_axi_rdata = st.rData;
	assign s_axi_rresp = st.rResp;
	assign rxAccept = st.accept;
	assign rxMailbox = st.mbIdx;
	assign rxFifoStore = st.fifoStore;
	// Clock gate enable for the protocol engine; dropped for the whole sleep
	assign moduleClkEn = (st.mode != CAF_MODE_SLEEP_RST) && (st.mode != CAF_MODE_SLEEP_HALT);

	sleepNoClock_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st.mode == CAF_MODE_SLEEP_RST || st.mode == CAF_MODE_SLEEP_HALT) |-> !moduleClkEn ##1 !rxAccept && !rxFifoStore)
		else $error("module active while asleep");
	resetWaits_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st.mode == CAF_MODE_OPERATE && st.opReq[0] && frameTxBusy) |=> st.mode == CAF_MODE_OPERATE)
		else $error("reset mode entered during transmission");
	haltWaits_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st.mode == CAF_MODE_OPERATE && st.opReq == CAF_OPM_HALT && (frameTxBusy || frameRxBusy))
		|=> !statWord[CAF_POS_HALT_ST])
		else $error("halt entered during a frame");
	haltEnters_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st.mode == CAF_MODE_OPERATE && st.opReq == CAF_OPM_HALT && !frameTxBusy && !frameRxBusy)
		|=> statWord[CAF_POS_HALT_ST])
		else $error("halt flag not raised after idle halt request");
	sleepReturn_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st.mode == CAF_MODE_SLEEP_HALT && !st.sleepReq) |=> st.mode == CAF_MODE_HALT
			&& $past(st.mode, 2) != CAF_MODE_SLEEP_RST)
		else $error("sleep exit did not return to halt");
	sleepOnlyStopped_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		st.mode == CAF_MODE_OPERATE |=> moduleClkEn)
		else $error("sleep entered straight from operation");
	fifoEither_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rxTaken && st.fifoMode && !anyMb) |=> rxFifoStore == $past(fifoHitA || fifoHitB))
		else $error("FIFO store does not follow its two filters");
	fifoNoMailbox_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rxAccept && $past(st.fifoMode)) |-> rxMailbox < FIFO_FIRST)
		else $error("FIFO mailbox matched through its identifier field");
	extNoSupport_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rxValid && rxIde) |=> $stable(supportWord))
		else $error("extended identifier reached the support register");
	writeAnswer_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(st.awHeld && st.wHeld && !st.bValid) |=> s_axi_bvalid && !s_axi_awready)
		else $error("write response missing after commit");
endmodule
`default_nettype wire

// [core/caf_filter_support.sv]
// Filter support register: latches a standard identifier and presents it split and decoded
`default_nettype none
module caf_filter_support
	import caf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic load,
	input wire logic [CAF_SID_W-1:0] sid,
	output logic [CAF_SUP_W-1:0] supportWord
);
	typedef struct packed {
		logic [7:0] upper;
		logic [7:0] decoded;
	} caf_sup_s;
	caf_sup_s st;
	caf_sup_s next_st;

	// Decode lower three identifier bits to one-hot at load time
	always_comb begin
		next_st = st;
		if (load) begin
			next_st.upper = sid[CAF_SID_W-1:3];
			next_st.decoded = 8'h01 << sid[2:0];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Register output keeps the read path free of the decoder
	always_comb begin
		supportWord = '0;
		supportWord[CAF_POS_SUP_HI +: 8] = st.upper;
		supportWord[CAF_POS_SUP_DEC +: 8] = st.decoded;
	end

	supLoad_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		load |=> supportWord[CAF_POS_SUP_HI +: 8] == $past(sid[CAF_SID_W-1:3]))
		else $error("support register missed a received identifier");
	supOneHot_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		load |=> $onehot(supportWord[CAF_POS_SUP_DEC +: 8])
			&& supportWord[CAF_POS_SUP_DEC + $past(sid[2:0])])
		else $error("support register decode is not the one-hot lower bits");
endmodule
`default_nettype wire

// [core/caf_id_match.sv]
// Masked comparison of one received identifier against one programmed filter word
`default_nettype none
module caf_id_match
	import caf_pkg::*;
(
	input wire logic [CAF_EID_W-1:0] rxId,
	input wire logic rxIde,
	input wire logic rxRtr,
	input wire logic [31:0] progWord,
	input wire logic [31:0] maskWord,
	input wire logic [1:0] idFormat,
	output logic hit
);
	logic mixed;
	logic [CAF_EID_W-1:0] idCare;
	logic idOk;
	logic rtrOk;
	logic ideOk;
	logic formatOk;

	// Compare only bits whose mask is one; standard frames carry just the top eleven bits
	always_comb begin
		mixed = (idFormat == CAF_IDFM_MIXED);
		if (rxIde) begin
			idCare = maskWord[CAF_EID_W-1:0];
		end else begin
			idCare = {maskWord[CAF_EID_W-1:CAF_POS_SID_LO], {CAF_POS_SID_LO{1'b0}}};
		end
		idOk = (((rxId ^ progWord[CAF_EID_W-1:0]) & idCare) == '0);
		rtrOk = !maskWord[CAF_POS_RTR] || (rxRtr == progWord[CAF_POS_RTR]);
		ideOk = !(mixed && maskWord[CAF_POS_IDE]) || (rxIde == progWord[CAF_POS_IDE]);
		// Single-format channels never see the other frame format as a hit
		if (mixed) begin
			formatOk = 1'b1;
		end else if (idFormat == CAF_IDFM_EXT) begin
			formatOk = rxIde;
		end else begin
			formatOk = !rxIde;
		end
		hit = idOk && rtrOk && ideOk && formatOk;
	end
endmodule
`default_nettype wire

// [dv/caf_acceptance_filter_tb.sv]
// Self-checking bench: register bus, mailbox and FIFO filters, support word, modes
`default_nettype none
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errTotal++; $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module caf_acceptance_filter_tb
	import caf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [1:0] fmt; logic [31:0] mask; logic [31:0] mb; logic [28:0] id; logic ide; logic rtr; logic acc;} caf_row_s;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [CAF_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic rxValid, rxIde, rxRtr, frameTxBusy, frameRxBusy, rxAccept, rxFifoStore, moduleClkEn;
	logic [CAF_EID_W-1:0] rxId;
	logic [4:0] rxMailbox, expMb = 5'h00;
	int errTotal = 0, nTests = 0, cyc = 0;
	// Software lookup table: upper identifier byte selects a row of valid one-hot lower values
	logic [7:0] lut [256] = '{default: 8'h00};
	// Format, mask 0, mailbox 0 word, received frame, expected acceptance
	caf_row_s rows [10] = '{
		'{2'h0, 32'hDFFC0000, 32'h048C0000, 29'h048C0000, 1'b0, 1'b0, 1'b1},
		'{2'h0, 32'hDFFC0000, 32'h048C0000, 29'h04900000, 1'b0, 1'b0, 1'b0},
		'{2'h0, 32'hDFFC0000, 32'h048C0000, 29'h048C0000, 1'b0, 1'b1, 1'b0},
		'{2'h0, 32'hDFFC0000, 32'h448C0000, 29'h048C0000, 1'b0, 1'b1, 1'b1},
		'{2'h0, 32'hDFF80000, 32'h04880000, 29'h048C0000, 1'b0, 1'b0, 1'b1},
		'{2'h0, 32'hDFF80000, 32'h04880000, 29'h04840000, 1'b0, 1'b0, 1'b0},
		'{2'h2, 32'hFFFFFFFF, 32'h92345678, 29'h12345678, 1'b1, 1'b0, 1'b1},
		'{2'h2, 32'hFFFFFFFF, 32'h92345678, 29'h12345679, 1'b1, 1'b0, 1'b0},
		'{2'h2, 32'hDFFC0000, 32'h048C0000, 29'h048C0000, 1'b1, 1'b0, 1'b0},
		'{2'h1, 32'hFFFFFFFF, 32'h12345678, 29'h12345678, 1'b1, 1'b0, 1'b1}
	};
	// Busy tx, busy rx, control word, expected status
	logic [16:0] modes [10] = '{{2'b10, 12'h000, 3'h0}, {2'b10, 12'h100, 3'h0}, {2'b00, 12'h100, 3'h1},
		{2'b00, 12'h500, 3'h5}, {2'b00, 12'h100, 3'h1}, {2'b01, 12'h000, 3'h0}, {2'b01, 12'h200, 3'h0},
		{2'b00, 12'h200, 3'h2}, {2'b00, 12'h600, 3'h6}, {2'b00, 12'h200, 3'h2}};

	caf_acceptance_filter u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(1'b1), .rxValid(rxValid), .rxId(rxId), .rxIde(rxIde), .rxRtr(rxRtr),
		.frameTxBusy(frameTxBusy), .frameRxBusy(frameRxBusy), .rxAccept(rxAccept),
		.rxMailbox(rxMailbox), .rxFifoStore(rxFifoStore), .moduleClkEn(moduleClkEn));
	caf_rx_partner u_part (.clk_sys(clk_sys), .rxValid(rxValid), .rxId(rxId), .rxIde(rxIde),
		.rxRtr(rxRtr), .frameTxBusy(frameTxBusy), .frameRxBusy(frameRxBusy));

	// 50 MHz clock
	initial forever #10 clk_sys = ~clk_sys;

	// Write: address and data offered together, each dropped once taken; ready lines stay high
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		resp = s_axi_bresp;
	endtask
	// Read: address held until taken, answer taken at the edge that shows rvalid
	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		v = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	// Pulses live one cycle, so they are looked at just after the sampling edge
	task automatic rxChk(input logic [28:0] id, input logic ide, input logic rtr, input logic acc, input logic ff);
		u_part.send(id, ide, rtr);
		#1;
		`CHK(rxAccept, acc)
		`CHK(rxFifoStore, ff)
		if (acc) `CHK(rxMailbox, expMb)
		@(posedge clk_sys);
	endtask
	task automatic printVerdict();
		$display("comparisons %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 8000) begin
			errTotal++;
			printVerdict();
		end
	end

	initial begin
		lut[8'hDE] = 8'h08;
		repeat (20) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		// Reset values, read-only and unmapped places
		rd(CAF_OFS_STATUS, d, r);
		`CHK(d, 32'h00000001)
		wr(12'hFFC, 32'hFFFFFFFF, r);
		`CHK(r, CAF_RESP_SLVERR)
		wr(CAF_OFS_SUPPORT, 32'hFFFFFFFF, r);
		rd(CAF_OFS_SUPPORT, d, r);
		`CHK({r, d}, {CAF_RESP_OKAY, 32'h0})
		$display("test reset done");
		// Mailbox filter table
		wr(CAF_OFS_RX_ENABLE, 32'h1, r);
		foreach (rows[i]) begin
			wr(CAF_OFS_MASK_BASE, rows[i].mask, r);
			wr(CAF_OFS_MB_BASE, rows[i].mb, r);
			wr(CAF_OFS_CONTROL, {30'h0, rows[i].fmt}, r);
			rxChk(rows[i].id, rows[i].ide, rows[i].rtr, rows[i].acc, 1'b0);
		end
		rd(CAF_OFS_MASK_BASE, d, r);
		`CHK(d, 32'hFFFFFFFF)
		$display("test mailbox rows done");
		// FIFO mode: mailbox 24 enabled but excluded, filter B ignores the low bit
		wr(CAF_OFS_CONTROL, 32'h4, r);
		wr(CAF_OFS_RX_ENABLE, 32'h01000000, r);
		wr(CAF_OFS_MB_BASE + 12'h060, 32'h0C000000, r);
		wr(CAF_OFS_MASK_BASE + 12'h018, 32'hDFFC0000, r);
		wr(CAF_OFS_MASK_BASE + 12'h01C, 32'hDFF80000, r);
		wr(CAF_OFS_FIFO_CMP_A, 32'h04000000, r);
		wr(CAF_OFS_FIFO_CMP_B, 32'h08000000, r);
		rxChk(29'h0C000000, 1'b0, 1'b0, 1'b0, 1'b0);
		rxChk(29'h04000000, 1'b0, 1'b0, 1'b0, 1'b1);
		rxChk(29'h08040000, 1'b0, 1'b0, 1'b0, 1'b1);
		rxChk(29'h04040000, 1'b0, 1'b0, 1'b0, 1'b0);
		rxChk(29'h1BCC0000, 1'b0, 1'b0, 1'b0, 1'b0);
		rd(CAF_OFS_SUPPORT, d, r);
		`CHK(d, 32'h000008DE)
		`CHK(|(lut[d[7:0]] & d[15:8]), 1'b1)
		rxChk(29'h12345678, 1'b1, 1'b0, 1'b0, 1'b0);
		rd(CAF_OFS_SUPPORT, d, r);
		`CHK(d, 32'h000008DE)
		$display("test fifo and support done");
		// Mode requests held off by frames, sleep entry and cancel
		foreach (modes[i]) begin
			u_part.busy(modes[i][16], modes[i][15]);
			wr(CAF_OFS_CONTROL, {20'h0, modes[i][14:3]}, r);
			rd(CAF_OFS_STATUS, d, r);
			`CHK(d, {29'h0, modes[i][2:0]})
			`CHK(moduleClkEn, !modes[i][2])
			if (modes[i][2]) rxChk(29'h0C000000, 1'b0, 1'b0, 1'b0, 1'b0);
		end
		// Back in normal mode the mailbox that FIFO mode shut out takes the frame
		wr(CAF_OFS_CONTROL, 32'h0, r);
		expMb = 5'h18;
		rxChk(29'h0C000000, 1'b0, 1'b0, 1'b1, 1'b0);
		$display("test modes done");
		// Reset in mid-run: handshakes idle, pulses low, control back to its reset value
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		`CHK({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, rxAccept, rxMailbox, moduleClkEn}, 12'hE01)
		arst_n <= 1'b1;
		@(posedge clk_sys);
		rd(CAF_OFS_CONTROL, d, r);
		`CHK(d, 32'h00000100)
		rd(CAF_OFS_MB_BASE + 12'h060, d, r);
		`CHK(d, 32'h0)
		$display("test reset again done");
		printVerdict();
	end
endmodule
`default_nettype wire

// [dv/caf_rx_partner.sv]
// Engine-side model: hands received frames and bus activity to the filter
`default_nettype none
module caf_rx_partner
	import caf_pkg::*;
(
	input wire logic clk_sys,
	output logic rxValid,
	output logic [CAF_EID_W-1:0] rxId,
	output logic rxIde,
	output logic rxRtr,
	output logic frameTxBusy,
	output logic frameRxBusy
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{rxValid, rxId, rxIde, rxRtr, frameTxBusy, frameRxBusy} = '0;
	end
	// One frame per call; lines show the inverse afterwards so stale values never match
	task automatic send(input logic [CAF_EID_W-1:0] id, input logic ide, input logic rtr);
		rxId <= id;
		rxIde <= ide;
		rxRtr <= rtr;
		rxValid <= 1'b1;
		@(posedge clk_sys);
		rxValid <= 1'b0;
		rxId <= ~id;
		rxIde <= ~ide;
		rxRtr <= ~rtr;
	endtask
	// Frame in progress on the bus, as levels
	task automatic busy(input logic tx, input logic rx);
		frameTxBusy <= tx;
		frameRxBusy <= rx;
	endtask
endmodule
`default_nettype wire

// [pkg/caf_pkg.sv]
// Package with register map, field positions, reset values and mode codes of the acceptance filter block
// Function
// - Mask one compares a bit, zero excludes it
// - Extension and remote flags compared under their masks
// - Extension flag compared only in mixed format
// - Remote flag selects remote or data frames
// - Cleared low mask bit accepts neighbour identifiers
// - Full mask extended filter needs exact match
// - Receive FIFO has two independent filters
// - FIFO filters use last two mask registers
// - FIFO filters compare FIFO registers, not mailboxes
// - Every received standard identifier loads filter support register
// - Support read: upper byte, one-hot lower bits
// - Support unit ignores extended identifiers
// - Sleep mode: no clock, no operation
// - Reset request waits for transmit frame end
// - Halt request waits for frame end, flags halt
// - Standard identifiers 11 bits, extended 29 bits
// - Sleep cancel returns to previous mode
`default_nettype none
package caf_pkg;
	localparam int CAF_NUM_MB = 32;
	localparam int CAF_MB_PER_MASK = 4;
	localparam int CAF_FIFO_BOXES = 8;
	localparam int CAF_ADDR_W = 12;
	localparam int CAF_SID_W = 11;
	localparam int CAF_EID_W = 29;
	localparam int CAF_SUP_W = 16;
	// Identifier and mask word layout
	localparam int CAF_POS_IDE = 31;
	localparam int CAF_POS_RTR = 30;
	localparam int CAF_POS_SID_LO = 18;
	// Control and status fields
	localparam int CAF_POS_IDFM = 0;
	localparam int CAF_POS_FIFO = 2;
	localparam int CAF_POS_OPM = 8;
	localparam int CAF_POS_SLEEP = 10;
	localparam int CAF_POS_RST_ST = 0;
	localparam int CAF_POS_HALT_ST = 1;
	localparam int CAF_POS_SLEEP_ST = 2;
	// Filter support word: upper byte low, decoded lower bits above it
	localparam int CAF_POS_SUP_HI = 0;
	localparam int CAF_POS_SUP_DEC = 8;
	// Byte offsets
	localparam logic [11:0] CAF_OFS_CONTROL = 12'h000;
	localparam logic [11:0] CAF_OFS_STATUS = 12'h004;
	localparam logic [11:0] CAF_OFS_SUPPORT = 12'h008;
	localparam logic [11:0] CAF_OFS_FIFO_CMP_A = 12'h00C;
	localparam logic [11:0] CAF_OFS_FIFO_CMP_B = 12'h010;
	localparam logic [11:0] CAF_OFS_RX_ENABLE = 12'h014;
	localparam logic [11:0] CAF_OFS_MASK_BASE = 12'h020;
	localparam logic [11:0] CAF_OFS_MB_BASE = 12'h080;
	// Codes
	localparam logic [1:0] CAF_IDFM_STD = 2'h0;
	localparam logic [1:0] CAF_IDFM_EXT = 2'h1;
	localparam logic [1:0] CAF_IDFM_MIXED = 2'h2;
	localparam logic [1:0] CAF_OPM_OPERATE = 2'h0;
	localparam logic [1:0] CAF_OPM_HALT = 2'h2;
	localparam logic [1:0] CAF_OPM_RST = 2'h1;
	localparam logic [1:0] CAF_IDFM_RST = 2'h0;
	localparam logic [1:0] CAF_RESP_OKAY = 2'h0;
	localparam logic [1:0] CAF_RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		CAF_MODE_OPERATE = 3'h0,
		CAF_MODE_RESET = 3'h1,
		CAF_MODE_HALT = 3'h2,
		CAF_MODE_SLEEP_RST = 3'h3,
		CAF_MODE_SLEEP_HALT = 3'h4
	} caf_mode_e;
endpackage
`default_nettype wire
